// ---- core/adio_pkg.sv ----
// package: register map, field codes and reset values of the auxiliary digital i/o port
package adio_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  // printed offsets are not all multiples of four (47110 is not): they are indices, byte address = 4 * index
  localparam int unsigned DIR_INDEX  = 47100;
  localparam int unsigned DATA_INDEX = 47110;
  localparam logic [19:0] DIR_ADDR   = 20'(DIR_INDEX * 4);
  localparam logic [19:0] DATA_ADDR  = 20'(DATA_INDEX * 4);
  localparam int unsigned ADDR_W     = 20;

  // ************************************************************
  // fields and codes
  // ************************************************************
  localparam int unsigned LINES      = 8;
  localparam int unsigned GROUP_W    = 4;
  localparam logic [1:0]  LOWER_GROUP_OUT = 2'h1;
  localparam logic [1:0]  UPPER_GROUP_OUT = 2'h2;
  localparam logic [1:0]  BOTH_GROUPS_IN  = 2'h0;
  localparam logic [7:0]  LINE_DATA_RESET = 8'h00;
  localparam int unsigned TRIG_A_BIT = 0;
  localparam int unsigned TRIG_B_BIT = 1;
  localparam int unsigned REFCLK_BIT = 2;

endpackage

// ---- core/adio_group.sv ----
// module: one four-line group buffer with shared direction
`timescale 1ns/1ps
module adio_group #(
  parameter int unsigned W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         drive,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] pin_o,
  output logic      [W-1:0] pin_oe_n,
  output logic      [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] out;
    logic [W-1:0] oe_n;
    logic [W-1:0] lvl;
  } adio_grp_st_t;

  adio_grp_st_t s_q;
  adio_grp_st_t s_d;

  always_comb
  begin
    s_d = s_q;
    // input groups drop written data
    if (wr_en && drive)
    begin
      s_d.out = wr_data; // [RULE10]
    end
    s_d.oe_n = {W{~drive}}; // [RULE1]
    s_d.lvl  = pin_i; // [RULE9]
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '{out: '0, oe_n: '1, lvl: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pin_o    = s_q.out;
  assign pin_oe_n = s_q.oe_n;
  assign level    = s_q.lvl;

endmodule // adio_group

// ---- core/adio_port.sv ----
// module: auxiliary digital i/o port with apb register slave
`timescale 1ns/1ps

// Function
// [RULE1] eight lines in two four-line groups, each group drives or receives together
// [RULE2] software sets each group's direction independently
// [RULE3] direction code 1 makes lower group output, 2 upper, OR combines
// [RULE4] lines run under software control, independent of acquisition
// [RULE5] software sets lower group to input before using special functions
// [RULE6] upper group direction stays free while special functions run
// [RULE7] lower input: lines 0,1 extra triggers, line 2 timestamp reference clock
// [RULE8] data reads sample every line, special ones too
// [RULE9] data register reads present pin levels, outputs read back driven pattern
// [RULE10] data writes only change lines of output groups
// [RULE11] bit n is line n, upper bytes ignored
// [RULE12] direction reads back last write, resets to both inputs
module adio_port (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [19:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  aux_line_i,
  output logic      [7:0]  aux_line_o,
  output logic      [7:0]  aux_line_oe_n,
  output logic             added_trigger_a,
  output logic             added_trigger_b,
  output logic             timestamp_reference_clock
);

  // ************************************************************
  // reset release
  // ************************************************************
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [1:0]  dir;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        trig_a;
    logic        trig_b;
    logic        refclk;
  } adio_st_t;

  adio_st_t s_q;
  adio_st_t s_d;

  logic [7:0] level;
  logic       acc;
  logic       wr_data;
  logic       hit_dir;
  logic       hit_data;

  assign acc      = psel && penable && !s_q.ready;
  assign hit_dir  = (paddr == adio_pkg::DIR_ADDR);
  assign hit_data = (paddr == adio_pkg::DATA_ADDR);
  assign wr_data  = acc && pwrite && hit_data;

  // ************************************************************
  // line groups
  // ************************************************************
  // no acquisition clock involved: lines follow software alone
  adio_group #(.W(adio_pkg::GROUP_W)) u_lower (
    .clk      (mclk),
    .rst_n    (rst_n),
    .drive    (s_q.dir[0]), // [RULE3]
    .wr_en    (wr_data), // [RULE4]
    .wr_data  (pwdata[3:0]), // [RULE11]
    .pin_i    (aux_line_i[3:0]),
    .pin_o    (aux_line_o[3:0]),
    .pin_oe_n (aux_line_oe_n[3:0]),
    .level    (level[3:0])
  );

  adio_group #(.W(adio_pkg::GROUP_W)) u_upper (
    .clk      (mclk),
    .rst_n    (rst_n),
    .drive    (s_q.dir[1]), // [RULE2] [RULE6]
    .wr_en    (wr_data),
    .wr_data  (pwdata[7:4]), // [RULE11]
    .pin_i    (aux_line_i[7:4]),
    .pin_o    (aux_line_o[7:4]),
    .pin_oe_n (aux_line_oe_n[7:4]),
    .level    (level[7:4])
  );

  // ************************************************************
  // apb slave and special routing
  // ************************************************************
  always_comb
  begin
    s_d       = s_q;
    s_d.ready = acc;
    s_d.err   = acc && !hit_dir && !hit_data;
    s_d.rdata = 32'h0;
    if (acc && !pwrite && hit_dir)
    begin
      s_d.rdata = {30'h0, s_q.dir}; // [RULE12]
    end
    if (acc && !pwrite && hit_data)
    begin
      // sampled pins, so outputs read back their pattern
      s_d.rdata = {24'h0, level}; // [RULE8] [RULE9]
    end
    if (acc && pwrite && hit_dir)
    begin
      s_d.dir = pwdata[1:0]; // [RULE2] [RULE3]
    end
    // specials only while lower group receives; otherwise held low
    s_d.trig_a = !s_q.dir[0] && level[adio_pkg::TRIG_A_BIT]; // [RULE7]
    s_d.trig_b = !s_q.dir[0] && level[adio_pkg::TRIG_B_BIT]; // [RULE7]
    s_d.refclk = !s_q.dir[0] && level[adio_pkg::REFCLK_BIT]; // [RULE7] [RULE5]
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '{dir: adio_pkg::BOTH_GROUPS_IN, rdata: 32'h0, ready: 1'h0, err: 1'h0,
               trig_a: 1'h0, trig_b: 1'h0, refclk: 1'h0}; // [RULE12]
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign prdata                    = s_q.rdata;
  assign pready                    = s_q.ready;
  assign pslverr                   = s_q.err;
  assign added_trigger_a           = s_q.trig_a;
  assign added_trigger_b           = s_q.trig_b;
  assign timestamp_reference_clock = s_q.refclk;

  // ************************************************************
  // checks
  // ************************************************************
  property p_dir_write;
    @(posedge mclk) disable iff (!rst_n)
      (acc && pwrite && hit_dir) |=> (s_q.dir == $past(pwdata[1:0]));
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction not stored"); // [RULE3]

  property p_lower_oe;
    @(posedge mclk) disable iff (!rst_n)
      $past(s_q.dir[0]) |-> (aux_line_oe_n[3:0] == 4'h0);
  endproperty
  a_lower_oe: assert property (p_lower_oe) else $error("lower group not driving"); // [RULE1]

  property p_upper_in;
    @(posedge mclk) disable iff (!rst_n)
      !$past(s_q.dir[1]) |-> (aux_line_oe_n[7:4] == 4'hF);
  endproperty
  a_upper_in: assert property (p_upper_in) else $error("upper group drives as input"); // [RULE2]

  property p_in_ignore;
    @(posedge mclk) disable iff (!rst_n)
      (wr_data && !s_q.dir[1]) |=> $stable(aux_line_o[7:4]);
  endproperty
  a_in_ignore: assert property (p_in_ignore) else $error("input group took write"); // [RULE10]

  property p_out_write;
    @(posedge mclk) disable iff (!rst_n)
      (wr_data && s_q.dir[0]) |=> (aux_line_o[3:0] == $past(pwdata[3:0]));
  endproperty
  a_out_write: assert property (p_out_write) else $error("output group missed write"); // [RULE10]

  sequence s_rd_data;
    acc && !pwrite && hit_data;
  endsequence
  property p_rd_pins;
    @(posedge mclk) disable iff (!rst_n)
      s_rd_data ##1 1'b1 |-> (prdata == {24'h0, $past(level)}) && pready;
  endproperty
  a_rd_pins: assert property (p_rd_pins) else $error("data read not pin levels"); // [RULE9]

  property p_rd_upper_zero;
    @(posedge mclk) disable iff (!rst_n)
      pready |-> (prdata[31:8] == 24'h0);
  endproperty
  a_rd_upper_zero: assert property (p_rd_upper_zero) else $error("upper bytes not zero"); // [RULE11]

  property p_trig_gate;
    @(posedge mclk) disable iff (!rst_n)
      $past(s_q.dir[0]) |-> !added_trigger_a && !added_trigger_b && !timestamp_reference_clock;
  endproperty
  a_trig_gate: assert property (p_trig_gate) else $error("special input while output"); // [RULE7]

  property p_dir_read;
    @(posedge mclk) disable iff (!rst_n)
      (acc && !pwrite && hit_dir) |=> (prdata == {30'h0, $past(s_q.dir)});
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction readback wrong"); // [RULE12]

  property p_lower_in;
    @(posedge mclk) disable iff (!rst_n)
      !$past(s_q.dir[0]) |-> (aux_line_oe_n[3:0] == 4'hF);
  endproperty
  a_lower_in: assert property (p_lower_in) else $error("lower group drives as input"); // [RULE2]

  // specials follow their lines while the lower group receives
  property p_trig_pass;
    @(posedge mclk) disable iff (!rst_n)
      !$past(s_q.dir[0]) |->
        (added_trigger_a == $past(level[adio_pkg::TRIG_A_BIT])) &&
        (added_trigger_b == $past(level[adio_pkg::TRIG_B_BIT])) &&
        (timestamp_reference_clock == $past(level[adio_pkg::REFCLK_BIT]));
  endproperty
  a_trig_pass: assert property (p_trig_pass) else $error("special input not routed"); // [RULE7]

endmodule // adio_port

// ---- sim/adio_ext_model.sv ----
// file: external equipment model wired to the eight aux lines
`timescale 1ns/1ps
module adio_ext_model (
  input  wire logic [7:0] ext_drive,
  input  wire logic [7:0] aux_line_o,
  input  wire logic [7:0] aux_line_oe_n,
  output logic      [7:0] aux_line_i
);
  // wire level: port wins where enabled, else equipment
  always_comb
  begin
    for (int n = 0; n < 8; n++)
      aux_line_i[n] = aux_line_oe_n[n] ? ext_drive[n] : aux_line_o[n];
  end
endmodule // adio_ext_model

// ---- sim/adio_port_tb_top.sv ----
// file: self-checking bench for the aux digital i/o port
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module adio_port_tb_top;
  logic        mclk, arst_n, psel, penable, pwrite;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, e, trg_a, trg_b, ref_clk;
  logic [7:0]  lin_i, lin_o, lin_oe_n, ext, lat, pat, oe;
  int          error_cnt, n_compared;

  adio_port adio_port_i (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .aux_line_i(lin_i), .aux_line_o(lin_o), .aux_line_oe_n(lin_oe_n),
    .added_trigger_a(trg_a), .added_trigger_b(trg_b), .timestamp_reference_clock(ref_clk));
  adio_ext_model adio_ext_model_i (.ext_drive(ext), .aux_line_o(lin_o),
    .aux_line_oe_n(lin_oe_n), .aux_line_i(lin_i));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic finish_test();
    if (n_compared > 0 && error_cnt == 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ************
  // apb master
  // ************
  // slave wait states come from the design, so poll pready with a bound
  task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      finish_test();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  initial
  begin
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    ext = 8'h5A;
    lat = 8'h00;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    `CHK(lin_oe_n, 8'hFF)
    apb(1'b0, adio_pkg::DIR_ADDR, 32'h0);
    `CHK(r, 32'h0)
    apb(1'b0, 20'h00010, 32'h0);
    `CHK(({e, r}), 33'h1_0000_0000)
    // every direction code; equipment pattern moves freely between steps
    for (int c = 0; c < 4; c++)
    begin
      ext <= 8'h3C ^ 8'(c * 33) ^ 8'(c >> 1);
      oe = {{4{~c[1]}}, {4{~c[0]}}};
      apb(1'b1, adio_pkg::DIR_ADDR, 32'hFFFF_FFF0 | 32'(c));
      // a newly driving group must show only writes made while it drove
      `CHK((lin_o & ~oe), (lat & ~oe))
      pat = 8'hA5 ^ 8'(c * 17);
      if (c[0])
        lat[3:0] = pat[3:0];
      if (c[1])
        lat[7:4] = pat[7:4];
      apb(1'b1, adio_pkg::DATA_ADDR, {24'hDEADBE, pat});
      `CHK(lin_oe_n, oe)
      apb(1'b0, adio_pkg::DIR_ADDR, 32'h0);
      `CHK(r, 32'(c))
      apb(1'b0, adio_pkg::DATA_ADDR, 32'h0);
      `CHK(r, ({24'h0, (lat & ~oe) | (ext & oe)}))
      `CHK(lin_o & ~oe, lat & ~oe)
      `CHK({ref_clk, trg_b, trg_a}, c[0] ? 3'h0 : ext[2:0])
    end
    finish_test();
  end
endmodule // adio_port_tb_top
